//--- wc_core_model.sv
// wc_core_model: crystal source and a sleeping core beside the block.
// assumes the bench pulses sleep_i; wake inputs come from the block.
`timescale 1ns/1ps
module wc_core_model (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // sleep request and wake lines
  input  wire logic sleep_i,
  input  wire logic wake_i,
  input  wire logic reg_wake_i,
  // crystal and core state
  output logic      xtal_o,
  output logic      awake_o
);
  // 16 ns period, far above the real rate, so one second fits the run;
  // each level lasts two system clocks, the least the filter accepts
  initial xtal_o = 1'b0;
  always #8 xtal_o = ~xtal_o;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awake_o <= 1'b1;
    end else if (sleep_i) begin
      awake_o <= 1'b0;
    end else if (!awake_o && wake_i && reg_wake_i) begin
      awake_o <= 1'b1;
    end
  end
endmodule : wc_core_model

//--- wc_edge_sync.sv
// wc_edge_sync: brings the crystal pin into the system clock domain.
// assumes the pin toggles far slower than the system clock.
`timescale 1ns/1ps
module wc_edge_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // pin side
  input  wire logic pin_i,
  // filtered level and its rising edge
  output logic      level_o,
  output logic      rise_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;

  // only a level seen by both later stages counts; spikes are dropped
  assign agree = (s2_reg == s3_reg);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      rise_o    <= 1'b0;
    end else begin
      s1_reg    <= pin_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= agree ? s3_reg : level_reg;
      rise_o    <= agree & s3_reg & ~level_reg;
    end
  end

  assign level_o = level_reg;
endmodule : wc_edge_sync

//--- wc_pkg.sv
// wc_pkg: constants shared by the watch clock block.
// assumes one 250 MHz system clock and a byte-addressed register port.
package wc_pkg;
  // system clock period, ns
  localparam int unsigned CLK_PERIOD_NS = 4;

  // crystal and tick rates
  localparam int unsigned CRYSTAL_HZ  = 32768;
  localparam int unsigned TICK_HZ     = 1;
  localparam int unsigned PRESCALE_DIV = CRYSTAL_HZ / TICK_HZ;
  localparam int unsigned PRE_W       = 15;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_DIV - 1);

  // counter widths and moduli
  localparam int unsigned SEC_W  = 6;
  localparam int unsigned MIN_W  = 6;
  localparam int unsigned HOUR_W = 5;
  localparam int unsigned DAY_W  = 15;
  localparam int unsigned SW_W   = 16;
  localparam logic [15:0] SEC_MOD  = 16'h003C;
  localparam logic [15:0] MIN_MOD  = 16'h003C;
  localparam logic [15:0] HOUR_MOD = 16'h0018;
  localparam logic [15:0] DAY_MOD  = 16'h8000;

  // register byte offsets
  localparam logic [7:0] OFF_TIME       = 8'h00;
  localparam logic [7:0] OFF_DAY        = 8'h04;
  localparam logic [7:0] OFF_ALARM_TIME = 8'h08;
  localparam logic [7:0] OFF_ALARM_DAY  = 8'h0C;
  localparam logic [7:0] OFF_CTRL       = 8'h10;
  localparam logic [7:0] OFF_STOPWATCH  = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam logic [7:0] OFF_MASK       = 8'h1C;
  localparam logic [7:0] OFF_WAKE_MASK  = 8'h20;

  // time word field positions
  localparam int unsigned SEC_LSB  = 0;
  localparam int unsigned MIN_LSB  = 8;
  localparam int unsigned HOUR_LSB = 16;

  // control bits
  localparam int unsigned CTRL_ALARM_EN = 0;
  localparam int unsigned CTRL_DATED    = 1;
  localparam int unsigned CTRL_SW_EN    = 2;
  localparam int unsigned CTRL_W        = 3;

  // status, mask and wake mask bits
  localparam int unsigned EV_SEC   = 0;
  localparam int unsigned EV_MIN   = 1;
  localparam int unsigned EV_HOUR  = 2;
  localparam int unsigned EV_DAY   = 3;
  localparam int unsigned EV_ALARM = 4;
  localparam int unsigned EV_SW    = 5;
  localparam int unsigned EV_W     = 6;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [EV_W-1:0]   MASK_RST = 6'h00;
  localparam logic [EV_W-1:0]   WAKE_RST = 6'h00;
endpackage : wc_pkg

//--- wc_prescale.sv
// wc_prescale: divides crystal edges down to the one-second tick.
// assumes one edge pulse per crystal period, from wc_edge_sync.
`timescale 1ns/1ps
module wc_prescale (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // crystal edge
  input  wire logic edge_i,
  // one-cycle second tick
  output logic      tick_o
);
  logic [wc_pkg::PRE_W-1:0] cnt_reg;
  logic                     last;

  assign last = (cnt_reg == wc_pkg::PRE_LAST);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      if (edge_i) begin
        cnt_reg <= last ? '0 : cnt_reg + 1'b1;
      end
      tick_o <= edge_i & last;
    end
  end
endmodule : wc_prescale

//--- wc_watch.sv
// wc_watch: calendar watch with alarm, stopwatch and tick interrupts.
// assumes an always-on supply and clock; host reaches it over a plain
// strobe port with read data one cycle after the read strobe.
//
// Contract
// - divide 32.768 kHz crystal down to a one-second tick.
// - seconds and minutes count modulo 60 and carry upward.
// - hours count modulo 24 and carry into a 32768-value day count.
// - enabled alarm interrupts as soon as counters equal alarm setting.
// - daily alarm compares time only; dated alarm also compares day.
// - stopwatch loads a written value and decrements each second.
// - enabled stopwatch raises interrupt when its count underflows past zero.
// - separately maskable interrupts on second, minute, hour, day rollover.
// - prescaler and counters keep running while the processor sleeps.
// - any wakeup event is signalled to bring processor out of sleep.
// - wakeup event also wakes deep sleep and the voltage regulator.
// - an event wakes the core only when its wake mask bit is set.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module wc_watch (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // crystal pins
  input  wire logic        watch_crystal_input_i,
  output logic             watch_crystal_output_o,
  // interrupt and wakeup
  output logic             irq_o,
  output logic             wake_o,
  output logic             regulator_wake_o
);
  localparam int unsigned SEC_W  = wc_pkg::SEC_W;
  localparam int unsigned MIN_W  = wc_pkg::MIN_W;
  localparam int unsigned HOUR_W = wc_pkg::HOUR_W;
  localparam int unsigned DAY_W  = wc_pkg::DAY_W;
  localparam int unsigned SW_W   = wc_pkg::SW_W;
  localparam int unsigned EV_W   = wc_pkg::EV_W;

  // next value of a modulo counter
  function automatic logic [15:0] wrap_inc(input logic [15:0] v,
                                           input logic [15:0] lim);
    logic [15:0] r;
    r = (v >= lim - 16'h0001) ? 16'h0000 : v + 16'h0001;
    return r;
  endfunction : wrap_inc

  // true when the counter is at its last value
  function automatic logic at_last(input logic [15:0] v,
                                   input logic [15:0] lim);
    logic r;
    r = (v >= lim - 16'h0001);
    return r;
  endfunction : at_last

  // crystal front end
  logic xtal_level;
  logic xtal_rise;
  logic tick;

  wc_edge_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (watch_crystal_input_i),
    .level_o   (xtal_level),
    .rise_o    (xtal_rise)
  );

  wc_prescale u_pre (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .edge_i    (xtal_rise),
    .tick_o    (tick)
  );

  // state
  logic [SEC_W-1:0]         sec_reg;
  logic [MIN_W-1:0]         min_reg;
  logic [HOUR_W-1:0]        hour_reg;
  logic [DAY_W-1:0]         day_reg;
  logic [SEC_W-1:0]         al_sec_reg;
  logic [MIN_W-1:0]         al_min_reg;
  logic [HOUR_W-1:0]        al_hour_reg;
  logic [DAY_W-1:0]         al_day_reg;
  logic [wc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [SW_W-1:0]          sw_reg;
  logic                     sw_run_reg;
  logic [EV_W-1:0]          status_reg;
  logic [EV_W-1:0]          mask_reg;
  logic [EV_W-1:0]          wake_mask_reg;
  logic                     match_reg;

  // register decode
  logic wr_time;
  logic wr_day;
  logic wr_al_time;
  logic wr_al_day;
  logic wr_ctrl;
  logic wr_sw;
  logic wr_status;
  logic wr_mask;
  logic wr_wake;

  assign wr_time    = wr_i & (addr_i == wc_pkg::OFF_TIME);
  assign wr_day     = wr_i & (addr_i == wc_pkg::OFF_DAY);
  assign wr_al_time = wr_i & (addr_i == wc_pkg::OFF_ALARM_TIME);
  assign wr_al_day  = wr_i & (addr_i == wc_pkg::OFF_ALARM_DAY);
  assign wr_ctrl    = wr_i & (addr_i == wc_pkg::OFF_CTRL);
  assign wr_sw      = wr_i & (addr_i == wc_pkg::OFF_STOPWATCH);
  assign wr_status  = wr_i & (addr_i == wc_pkg::OFF_STATUS);
  assign wr_mask    = wr_i & (addr_i == wc_pkg::OFF_MASK);
  assign wr_wake    = wr_i & (addr_i == wc_pkg::OFF_WAKE_MASK);

  // write data fields
  logic [SEC_W-1:0]  w_sec;
  logic [MIN_W-1:0]  w_min;
  logic [HOUR_W-1:0] w_hour;

  assign w_sec  = wdata_i[wc_pkg::SEC_LSB +: SEC_W];
  assign w_min  = wdata_i[wc_pkg::MIN_LSB +: MIN_W];
  assign w_hour = wdata_i[wc_pkg::HOUR_LSB +: HOUR_W];

  // time-keeping carries; counters run on the tick alone, so they keep
  // going whatever power state the core is in
  logic sec_roll;
  logic min_roll;
  logic hour_roll;
  logic day_roll;

  assign sec_roll  = tick & at_last(16'(sec_reg), wc_pkg::SEC_MOD);
  assign min_roll  = sec_roll
                   & at_last(16'(min_reg), wc_pkg::MIN_MOD);
  assign hour_roll = min_roll
                   & at_last(16'(hour_reg), wc_pkg::HOUR_MOD);
  assign day_roll  = hour_roll
                   & at_last(16'(day_reg), wc_pkg::DAY_MOD);

  logic [SEC_W-1:0]  sec_next;
  logic [MIN_W-1:0]  min_next;
  logic [HOUR_W-1:0] hour_next;
  logic [DAY_W-1:0]  day_next;

  // a software load wins over a tick in the same cycle
  assign sec_next  = wr_time ? w_sec
                   : tick ? SEC_W'(wrap_inc(16'(sec_reg), wc_pkg::SEC_MOD))
                   : sec_reg;
  assign min_next  = wr_time ? w_min
                   : sec_roll
                     ? MIN_W'(wrap_inc(16'(min_reg), wc_pkg::MIN_MOD))
                   : min_reg;
  assign hour_next = wr_time ? w_hour
                   : min_roll
                     ? HOUR_W'(wrap_inc(16'(hour_reg), wc_pkg::HOUR_MOD))
                   : hour_reg;
  assign day_next  = wr_day ? wdata_i[DAY_W-1:0]
                   : hour_roll
                     ? DAY_W'(wrap_inc(16'(day_reg), wc_pkg::DAY_MOD))
                   : day_reg;

  // alarm compare
  logic alarm_en;
  logic alarm_dated;
  logic time_eq;
  logic match;

  assign alarm_en    = ctrl_reg[wc_pkg::CTRL_ALARM_EN];
  assign alarm_dated = ctrl_reg[wc_pkg::CTRL_DATED];
  assign time_eq = (sec_reg == al_sec_reg) && (min_reg == al_min_reg)
                && (hour_reg == al_hour_reg);
  assign match   = time_eq
                && (!alarm_dated || (day_reg == al_day_reg));

  // stopwatch
  logic sw_en;
  logic sw_under;
  logic [SW_W-1:0] sw_next;
  logic sw_run_next;

  assign sw_en    = ctrl_reg[wc_pkg::CTRL_SW_EN];
  // a tick that finds zero is the underflow; the count then parks at zero
  assign sw_under = tick & sw_en & sw_run_reg & (sw_reg == '0);
  assign sw_next  = wr_sw ? wdata_i[SW_W-1:0]
                  : (tick & sw_en & sw_run_reg & (sw_reg != '0))
                    ? sw_reg - 1'b1
                  : sw_reg;
  assign sw_run_next = wr_sw ? 1'b1 : sw_under ? 1'b0 : sw_run_reg;

  // events, set wins over a write-one clear
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clr_bits;
  logic [EV_W-1:0] status_next;

  assign events[wc_pkg::EV_SEC]   = tick;
  assign events[wc_pkg::EV_MIN]   = sec_roll;
  assign events[wc_pkg::EV_HOUR]  = min_roll;
  assign events[wc_pkg::EV_DAY]   = hour_roll;
  // only the first cycle of a match counts, so one match gives one event
  assign events[wc_pkg::EV_ALARM] = alarm_en & match & ~match_reg;
  assign events[wc_pkg::EV_SW]    = sw_under;
  assign clr_bits    = wr_status ? wdata_i[EV_W-1:0] : '0;
  assign status_next = (status_reg & ~clr_bits) | events;

  // interrupt and wakeup
  logic irq_next;
  logic wake_next;

  assign irq_next  = |(status_reg & mask_reg);
  // wake request is independent of the interrupt mask
  assign wake_next = |(status_reg & wake_mask_reg);

  // read mux
  logic [31:0] rd_mux;
  logic [31:0] time_word;
  logic [31:0] al_time_word;

  assign time_word    = {11'h000, hour_reg, 2'h0, min_reg, 2'h0, sec_reg};
  assign al_time_word = {11'h000, al_hour_reg, 2'h0, al_min_reg,
                         2'h0, al_sec_reg};

  always_comb begin
    unique case (addr_i)
      wc_pkg::OFF_TIME:       rd_mux = time_word;
      wc_pkg::OFF_DAY:        rd_mux = {17'h00000, day_reg};
      wc_pkg::OFF_ALARM_TIME: rd_mux = al_time_word;
      wc_pkg::OFF_ALARM_DAY:  rd_mux = {17'h00000, al_day_reg};
      wc_pkg::OFF_CTRL:       rd_mux = {29'h00000000, ctrl_reg};
      wc_pkg::OFF_STOPWATCH:  rd_mux = {16'h0000, sw_reg};
      wc_pkg::OFF_STATUS:     rd_mux = {26'h0000000, status_reg};
      wc_pkg::OFF_MASK:       rd_mux = {26'h0000000, mask_reg};
      wc_pkg::OFF_WAKE_MASK:  rd_mux = {26'h0000000, wake_mask_reg};
      default:                rd_mux = 32'h00000000;
    endcase
  end

  // time counters
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_reg  <= '0;
      min_reg  <= '0;
      hour_reg <= '0;
      day_reg  <= '0;
    end else begin
      sec_reg  <= sec_next;
      min_reg  <= min_next;
      hour_reg <= hour_next;
      day_reg  <= day_next;
    end
  end

  // software settings
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      al_sec_reg    <= '0;
      al_min_reg    <= '0;
      al_hour_reg   <= '0;
      al_day_reg    <= '0;
      ctrl_reg      <= wc_pkg::CTRL_RST;
      mask_reg      <= wc_pkg::MASK_RST;
      wake_mask_reg <= wc_pkg::WAKE_RST;
    end else begin
      if (wr_al_time) begin
        al_sec_reg  <= w_sec;
        al_min_reg  <= w_min;
        al_hour_reg <= w_hour;
      end
      if (wr_al_day) begin
        al_day_reg <= wdata_i[DAY_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_reg <= wdata_i[wc_pkg::CTRL_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= wdata_i[EV_W-1:0];
      end
      if (wr_wake) begin
        wake_mask_reg <= wdata_i[EV_W-1:0];
      end
    end
  end

  // stopwatch, status and outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_reg                 <= '0;
      sw_run_reg             <= 1'b0;
      status_reg             <= '0;
      match_reg              <= 1'b0;
      irq_o                  <= 1'b0;
      wake_o                 <= 1'b0;
      regulator_wake_o       <= 1'b0;
      rdata_o                <= 32'h00000000;
      watch_crystal_output_o <= 1'b0;
    end else begin
      sw_reg     <= sw_next;
      sw_run_reg <= sw_run_next;
      status_reg <= status_next;
      match_reg  <= match;
      irq_o      <= irq_next;
      wake_o     <= wake_next;
      // same request also reaches the deep-sleep and regulator wake path
      regulator_wake_o <= wake_next;
      rdata_o    <= rd_i ? rd_mux : 32'h00000000;
      // inverted drive back to the crystal, one feedback stage
      watch_crystal_output_o <= ~xtal_level;
    end
  end
endmodule : wc_watch

//--- wc_watch_bench.sv
// wc_watch_bench: register-level tests of the watch clock block.
// assumes the core model supplies the crystal and plays the sleeping core.
`timescale 1ns/1ps
module wc_watch_bench;
  logic        clk_sys_i  = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic [7:0]  addr_i     = 8'h00;
  logic [31:0] wdata_i    = 32'h0;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic        sleep      = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic        xtal, xtal_out, irq_o, wake_o, reg_wake, awake;
  int          error_cnt  = 0;
  int          num_checks = 0;
  logic [7:0]  sa [8] = '{8'h08, 8'h0C, 8'h10, 8'h04, 8'h00, 8'h14, 8'h1C,
                          8'h20};
  logic [31:0] sd [8] = '{32'h0, 32'h0, 32'h7, 32'h7FFF, 32'h0017_3B3B,
                          32'h0, 32'h3F, 32'h20};

  always #2 clk_sys_i = ~clk_sys_i;

  wc_watch wc_watch_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .watch_crystal_input_i(xtal), .watch_crystal_output_o(xtal_out),
    .irq_o(irq_o), .wake_o(wake_o), .regulator_wake_o(reg_wake));
  wc_core_model wc_core_model_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sleep_i(sleep),
    .wake_i(wake_o), .reg_wake_i(reg_wake), .xtal_o(xtal),
    .awake_o(awake));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  // write then read the same register with no gap between the strobes
  task automatic wrrc(input logic [7:0] a, input logic [31:0] v,
                      input logic [31:0] exp);
    logic [31:0] q;
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    @(posedge clk_sys_i);
    rd_i    <= 1'b0;
    #1 q = rdata_o;
    check(q, exp);
  endtask : wrrc

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask : rc

  // polls the second-tick flag; the tick lands about 131k cycles apart
  task automatic wait_tick;
    d = 32'h0;
    for (int n = 0; n < 70000 && d[0] !== 1'b1; n++) rd(8'h18, d);
    repeat (4) @(posedge clk_sys_i);
  endtask : wait_tick

  task automatic print_verdict;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #600_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rc(8'(a), 32'h0);
    wr(8'h24, 32'hFFFF_FFFF);
    rc(8'h24, 32'h0);
    wr(wc_pkg::OFF_MASK, 32'h10);
    wr(wc_pkg::OFF_ALARM_TIME, 32'h0001_0203);
    wr(wc_pkg::OFF_ALARM_DAY, 32'h5);
    wr(wc_pkg::OFF_CTRL, 32'h1);
    wr(wc_pkg::OFF_TIME, 32'h0001_0203);
    rc(wc_pkg::OFF_TIME, 32'h0001_0203);
    rc(wc_pkg::OFF_STATUS, 32'h10);
    check({31'h0, irq_o}, 32'h1);
    // dated form must also see the day, which differs here
    wr(wc_pkg::OFF_STATUS, 32'h10);
    wr(wc_pkg::OFF_CTRL, 32'h3);
    wr(wc_pkg::OFF_TIME, 32'h0001_0204);
    wr(wc_pkg::OFF_TIME, 32'h0001_0203);
    rc(wc_pkg::OFF_STATUS, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    wrrc(wc_pkg::OFF_STOPWATCH, 32'h1234, 32'h1234);
    // one second only fits the run: the stopwatch is loaded with zero so
    // that the single tick underflows it
    for (int i = 0; i < 8; i++) wr(sa[i], sd[i]);
    wrrc(wc_pkg::OFF_CTRL, 32'h7, 32'h7);
    wrrc(wc_pkg::OFF_MASK, 32'h3F, 32'h3F);
    rc(wc_pkg::OFF_DAY, 32'h7FFF);
    rc(wc_pkg::OFF_STOPWATCH, 32'h0);
    rc(wc_pkg::OFF_WAKE_MASK, 32'h20);
    sleep <= 1'b1;
    @(posedge clk_sys_i);
    sleep <= 1'b0;
    wait_tick();
    rc(wc_pkg::OFF_STATUS, 32'h3F);
    rc(wc_pkg::OFF_TIME, 32'h0);
    rc(wc_pkg::OFF_DAY, 32'h0);
    rc(wc_pkg::OFF_STOPWATCH, 32'h0);
    check({31'h0, irq_o}, 32'h1);
    check({31'h0, wake_o}, 32'h1);
    check({31'h0, awake}, 32'h1);
    check({31'h0, reg_wake}, 32'h1);
    wr(wc_pkg::OFF_WAKE_MASK, 32'h0);
    rc(wc_pkg::OFF_WAKE_MASK, 32'h0);
    check({31'h0, wake_o}, 32'h0);
    wr(wc_pkg::OFF_MASK, 32'h0);
    rc(wc_pkg::OFF_STATUS, 32'h3F);
    check({31'h0, irq_o}, 32'h0);
    wr(wc_pkg::OFF_STATUS, 32'h20);
    rc(wc_pkg::OFF_STATUS, 32'h1F);
    wr(wc_pkg::OFF_STATUS, 32'h1F);
    rc(wc_pkg::OFF_STATUS, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    print_verdict();
  end
endmodule : wc_watch_bench

bind wc_watch wc_watch_checker wc_watch_checker_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .wake_o(wake_o), .regulator_wake_o(regulator_wake_o));

//--- wc_watch_checker.sv
// wc_watch_checker: port-level properties of the watch clock block.
// assumes it is bound onto wc_watch and sees only its ports.
`timescale 1ns/1ps
module wc_watch_checker (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // interrupt and wakeup
  input wire logic        irq_o,
  input wire logic        wake_o,
  input wire logic        regulator_wake_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  wire logic mapped = (addr_i[1:0] == 2'h0) && (addr_i <= 8'h20);

  // a mask write not overwritten next cycle, so the result is settled
  sequence s_mask_off;
    wr_i && addr_i == wc_pkg::OFF_MASK && wdata_i[5:0] == 6'h00
    ##1 !(wr_i && addr_i == wc_pkg::OFF_MASK);
  endsequence
  sequence s_wake_off;
    wr_i && addr_i == wc_pkg::OFF_WAKE_MASK && wdata_i[5:0] == 6'h00
    ##1 !(wr_i && addr_i == wc_pkg::OFF_WAKE_MASK);
  endsequence
  sequence s_ctrl_wr_rd;
    wr_i && addr_i == wc_pkg::OFF_CTRL ##1 rd_i && addr_i == wc_pkg::OFF_CTRL;
  endsequence
  sequence s_mask_wr_rd;
    wr_i && addr_i == wc_pkg::OFF_MASK ##1 rd_i && addr_i == wc_pkg::OFF_MASK;
  endsequence

  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  property p_unmapped;
    rd_i && !mapped |=> rdata_o == 32'h0;
  endproperty
  property p_irq_off;
    s_mask_off |=> !irq_o;
  endproperty
  property p_wake_off;
    s_wake_off |=> !wake_o;
  endproperty
  property p_ctrl_back;
    s_ctrl_wr_rd |=> rdata_o == {29'h0, $past(wdata_i[2:0], 2)};
  endproperty
  property p_mask_back;
    s_mask_wr_rd |=> rdata_o == {26'h0, $past(wdata_i[5:0], 2)};
  endproperty
  property p_day_width;
    rd_i && addr_i == wc_pkg::OFF_DAY |=> rdata_o[31:15] == 17'h0;
  endproperty
  property p_reg_wake;
    regulator_wake_o == wake_o;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with mask cleared");
  a_wake_off: assert property (p_wake_off)
    else $error("wake high with wake mask cleared");
  a_ctrl_back: assert property (p_ctrl_back)
    else $error("control readback wrong");
  a_mask_back: assert property (p_mask_back)
    else $error("mask readback wrong");
  a_day_width: assert property (p_day_width)
    else $error("day read wider than 15 bits");
  a_reg_wake: assert property (p_reg_wake)
    else $error("regulator wake differs from wake");
endmodule : wc_watch_checker
